// >>> core/pmbus_cmd_pkg.sv
package pmbus_cmd_pkg;

	// ***************************
	// command codes
	// ***************************
	localparam logic [7:0] CMD_PAGE       = 8'h00;
	localparam logic [7:0] CMD_RUN        = 8'h01;
	localparam logic [7:0] CMD_PIN_SETUP  = 8'h02;
	localparam logic [7:0] CMD_CLEAR      = 8'h03;
	localparam logic [7:0] CMD_LOCK       = 8'h10;
	localparam logic [7:0] CMD_STORE_ALL  = 8'h11;
	localparam logic [7:0] CMD_STORE_ONE  = 8'h13;
	localparam logic [7:0] CMD_COMM_FLAGS = 8'h7e;

	// ***************************
	// reset values and writable masks
	// ***************************
	localparam logic [7:0] RUN_RESET  = 8'h00;
	localparam logic [7:0] RUN_WMASK  = 8'hbc;
	localparam logic [7:0] PIN_RESET  = 8'h16;
	localparam logic [7:0] PIN_WMASK  = 8'h1f;
	localparam logic [7:0] LOCK_RESET = 8'h00;
	localparam logic [7:0] LOCK_WMASK = 8'he0;
	localparam logic [7:0] IDLE_BYTE  = 8'hff;

	// ***************************
	// field positions
	// ***************************
	localparam int RUN_ON_BIT     = 7;
	localparam int MARGIN_LSB     = 4;
	localparam int PIN_USE_BIT    = 4;
	localparam int PIN_CMD_BIT    = 3;
	localparam int PIN_PIN_BIT    = 2;
	localparam int PIN_POL_BIT    = 1;
	localparam int LOCK_ALL_BIT   = 7;
	localparam int LOCK_RUN_BIT   = 6;
	localparam int LOCK_PIN_BIT   = 5;
	localparam int CML_CMD_BIT    = 7;
	localparam int CML_DATA_BIT   = 6;
	localparam int CML_PEC_BIT    = 5;

	// ***************************
	// framing and timing
	// ***************************
	localparam logic [3:0] BYTE_BITS  = 4'h8;
	localparam logic [2:0] LEN_SEND   = 3'h1;
	localparam logic [2:0] LEN_WRITE  = 3'h2;
	localparam logic [7:0] CRC_POLY   = 8'h07;
	localparam int         CLK_KHZ         = 125000;
	localparam int         STORE_ALL_MS    = 50;
	localparam int         STORE_ALL_CYCLES = CLK_KHZ * STORE_ALL_MS;
	localparam int         WAIT_W          = 23;

	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} bus_state_e;

endpackage

// >>> core/pmbus_command_handler.sv
// What this block does
// - code 01 takes a byte that turns the output on or off and picks the margin setting.
// - code 02 takes a byte choosing how the enable pin and bus commands gate turn-on.
// - code 03 clears all latched fault flags and releases the alert line.
// - code 10 holds a lock byte that decides which later writes are taken.
// - with lock bit 5 clear, writes are limited only by lock bits 6 and 7.
// - lock bit 5 allows only lock, page, run/margin and pin setup writes, with bits 6, 7 zero.
// - lock bit 6 allows only lock, page and run/margin writes, with bits 5, 7 zero.
// - the single store command saves the register whose code is the data byte.
// - code 11 saves every register, and the host waits about 50 ms before going on.
// - in every status byte a one means the condition is flagged.
// - bad commands, bad data and a failed packet check set comm flags at bits 7, 6 and 5.
`timescale 1ns/1ps
module pmbus_command_handler #(
	parameter logic [6:0] DEV_ADDR        = 7'h40,
	parameter int         NVM_WAIT_CYCLES = pmbus_cmd_pkg::STORE_ALL_CYCLES
) (
	// clock and reset
	input  wire logic       I_CLK,
	input  wire logic       I_RESET_N,
	// bus pins
	input  wire logic       I_SCL,
	input  wire logic       I_SDA,
	output logic            O_SDA_OUT,
	output logic            O_SDA_OE,
	output logic            O_ALERT_OUT,
	output logic            O_ALERT_OE,
	// converter side
	input  wire logic       I_ENABLE_PIN,
	input  wire logic [7:0] I_FAULT_SET,
	output logic            O_OUTPUT_ON,
	output logic [1:0]      O_MARGIN,
	output logic [7:0]      O_FAULT_FLAGS,
	// non-volatile store side
	output logic            O_NVM_STORE_ALL,
	output logic            O_NVM_STORE_ONE,
	output logic [7:0]      O_NVM_CODE,
	output logic [7:0]      O_NVM_DATA,
	output logic            O_NVM_BUSY
);

	// ***************************
	// declarations
	// ***************************
	pmbus_cmd_pkg::bus_state_e state;
	logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, pin_m, pin_s;
	logic scl_rise, scl_fall, start, stop;
	logic       in_txn, first, rd_mode, host_ack, tx_more, rd_err;
	logic [3:0] bit_cnt;
	logic [7:0] shreg, crc, crc_prev, b_cmd, b_data, b_last;
	logic [2:0] nbytes, exp_len;
	logic [7:0] run_margin_control, enable_pin_setup, write_lock, comm_fault_flags;
	logic [7:0] next_tx, next_cml;
	logic       wr_done, known, pec_bad, len_ok, permitted, data_bad, commit;
	logic [pmbus_cmd_pkg::WAIT_W-1:0] wait_cnt;

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ pmbus_cmd_pkg::CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	function automatic logic readable(input logic [7:0] code);
		return code == pmbus_cmd_pkg::CMD_RUN || code == pmbus_cmd_pkg::CMD_PIN_SETUP ||
			code == pmbus_cmd_pkg::CMD_LOCK;
	endfunction

	function automatic logic [7:0] reg_value(input logic [7:0] code);
		case (code)
			pmbus_cmd_pkg::CMD_RUN:        return run_margin_control;
			pmbus_cmd_pkg::CMD_PIN_SETUP:  return enable_pin_setup;
			pmbus_cmd_pkg::CMD_LOCK:       return write_lock;
			pmbus_cmd_pkg::CMD_COMM_FLAGS: return comm_fault_flags;
			default:                       return pmbus_cmd_pkg::IDLE_BYTE;
		endcase
	endfunction

	// ***************************
	// pin synchronisers and bus events
	// ***************************
	always_ff @(posedge I_CLK) begin
		scl_m <= I_SCL;
		scl_s <= scl_m;
		scl_d <= scl_s;
		sda_m <= I_SDA;
		sda_s <= sda_m;
		sda_d <= sda_s;
		pin_m <= I_ENABLE_PIN;
		pin_s <= pin_m;
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start    = scl_s & scl_d & sda_d & ~sda_s;
	assign stop     = scl_s & scl_d & ~sda_d & sda_s;

	// ***************************
	// write decode, judged at stop
	// ***************************
	always_comb begin
		case (b_cmd)
			pmbus_cmd_pkg::CMD_CLEAR, pmbus_cmd_pkg::CMD_STORE_ALL: exp_len = pmbus_cmd_pkg::LEN_SEND;
			pmbus_cmd_pkg::CMD_PAGE, pmbus_cmd_pkg::CMD_RUN, pmbus_cmd_pkg::CMD_PIN_SETUP,
			pmbus_cmd_pkg::CMD_LOCK, pmbus_cmd_pkg::CMD_STORE_ONE:  exp_len = pmbus_cmd_pkg::LEN_WRITE;
			default:                                                exp_len = 3'h0;
		endcase
		wr_done = stop & in_txn & ~rd_mode & (nbytes != 3'h0);
		known   = exp_len != 3'h0;
		pec_bad = (nbytes == exp_len + 3'h1) && (b_last != crc_prev);
		len_ok  = (nbytes == exp_len) || ((nbytes == exp_len + 3'h1) && !pec_bad);
		if (write_lock[pmbus_cmd_pkg::LOCK_ALL_BIT])
			permitted = b_cmd == pmbus_cmd_pkg::CMD_LOCK;
		else if (write_lock[pmbus_cmd_pkg::LOCK_RUN_BIT])
			permitted = b_cmd == pmbus_cmd_pkg::CMD_LOCK || b_cmd == pmbus_cmd_pkg::CMD_PAGE ||
				b_cmd == pmbus_cmd_pkg::CMD_RUN;
		else if (write_lock[pmbus_cmd_pkg::LOCK_PIN_BIT])
			permitted = b_cmd == pmbus_cmd_pkg::CMD_LOCK || b_cmd == pmbus_cmd_pkg::CMD_PAGE ||
				b_cmd == pmbus_cmd_pkg::CMD_RUN || b_cmd == pmbus_cmd_pkg::CMD_PIN_SETUP;
		else
			permitted = 1'b1;
		// more than one lock level at once is refused as bad data
		data_bad = (b_cmd == pmbus_cmd_pkg::CMD_LOCK &&
				$countones(b_data & pmbus_cmd_pkg::LOCK_WMASK) > 1) ||
			(b_cmd == pmbus_cmd_pkg::CMD_STORE_ONE && !readable(b_data));
		commit = wr_done & known & len_ok & permitted & ~data_bad;
		next_tx = (state == pmbus_cmd_pkg::ST_RX_ACK) ? reg_value(b_cmd) :
			(tx_more ? crc : pmbus_cmd_pkg::IDLE_BYTE);
	end

	// ***************************
	// bus engine
	// ***************************
	always_ff @(posedge I_CLK) begin
		rd_err <= 1'b0;
		if (!I_RESET_N) begin
			state    <= pmbus_cmd_pkg::ST_IDLE;
			O_SDA_OE <= 1'b0;
			in_txn   <= 1'b0;
			first    <= 1'b0;
			rd_mode  <= 1'b0;
			host_ack <= 1'b0;
			tx_more  <= 1'b0;
			bit_cnt  <= 4'h0;
			shreg    <= 8'h00;
			crc      <= 8'h00;
			crc_prev <= 8'h00;
			nbytes   <= 3'h0;
			b_cmd    <= 8'h00;
			b_data   <= 8'h00;
			b_last   <= 8'h00;
		end else if (start) begin
			state    <= pmbus_cmd_pkg::ST_RX;
			O_SDA_OE <= 1'b0;
			in_txn   <= 1'b1;
			first    <= 1'b1;
			bit_cnt  <= 4'h0;
			if (!in_txn) begin
				crc    <= 8'h00;
				nbytes <= 3'h0;
			end
		end else if (stop) begin
			state    <= pmbus_cmd_pkg::ST_IDLE;
			O_SDA_OE <= 1'b0;
			in_txn   <= 1'b0;
			rd_mode  <= 1'b0;
		end else begin
			case (state)
				pmbus_cmd_pkg::ST_RX: begin
					if (scl_rise && bit_cnt != pmbus_cmd_pkg::BYTE_BITS) begin
						shreg   <= {shreg[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == pmbus_cmd_pkg::BYTE_BITS) begin
						if (first && shreg[7:1] != DEV_ADDR) begin
							state <= pmbus_cmd_pkg::ST_IDLE;
						end else begin
							O_SDA_OE <= 1'b1;
							state    <= pmbus_cmd_pkg::ST_RX_ACK;
							crc_prev <= crc;
							crc      <= crc8(crc, shreg);
							if (first) begin
								rd_mode <= shreg[0];
							end else begin
								if (nbytes != 3'h7)
									nbytes <= nbytes + 3'h1;
								if (nbytes == 3'h0)
									b_cmd <= shreg;
								if (nbytes == 3'h1)
									b_data <= shreg;
								b_last <= shreg;
							end
						end
					end
				end
				pmbus_cmd_pkg::ST_RX_ACK: begin
					if (scl_fall) begin
						first   <= 1'b0;
						bit_cnt <= 4'h0;
						if (rd_mode) begin
							state    <= pmbus_cmd_pkg::ST_TX;
							shreg    <= next_tx;
							O_SDA_OE <= ~next_tx[7];
							crc      <= crc8(crc, next_tx);
							tx_more  <= 1'b1;
							rd_err   <= next_tx == pmbus_cmd_pkg::IDLE_BYTE &&
								b_cmd != pmbus_cmd_pkg::CMD_COMM_FLAGS;
						end else begin
							O_SDA_OE <= 1'b0;
							state    <= pmbus_cmd_pkg::ST_RX;
						end
					end
				end
				pmbus_cmd_pkg::ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt == pmbus_cmd_pkg::BYTE_BITS - 4'h1) begin
							O_SDA_OE <= 1'b0;
							host_ack <= 1'b0;
							state    <= pmbus_cmd_pkg::ST_TX_ACK;
						end else begin
							shreg    <= {shreg[6:0], 1'b0};
							O_SDA_OE <= ~shreg[6];
							bit_cnt  <= bit_cnt + 4'h1;
						end
					end
				end
				pmbus_cmd_pkg::ST_TX_ACK: begin
					if (scl_rise) begin
						host_ack <= ~sda_s;
					end else if (scl_fall) begin
						if (host_ack) begin
							state    <= pmbus_cmd_pkg::ST_TX;
							shreg    <= next_tx;
							O_SDA_OE <= ~next_tx[7];
							tx_more  <= 1'b0;
							bit_cnt  <= 4'h0;
						end else begin
							state <= pmbus_cmd_pkg::ST_IDLE;
						end
					end
				end
				pmbus_cmd_pkg::ST_IDLE: begin
				end
				default: state <= pmbus_cmd_pkg::ST_IDLE;
			endcase
		end
	end

	// ***************************
	// control registers
	// ***************************
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			run_margin_control <= pmbus_cmd_pkg::RUN_RESET;
			enable_pin_setup   <= pmbus_cmd_pkg::PIN_RESET;
			write_lock         <= pmbus_cmd_pkg::LOCK_RESET;
		end else if (commit) begin
			case (b_cmd)
				pmbus_cmd_pkg::CMD_RUN: run_margin_control <=
					(run_margin_control & ~pmbus_cmd_pkg::RUN_WMASK) | (b_data & pmbus_cmd_pkg::RUN_WMASK);
				pmbus_cmd_pkg::CMD_PIN_SETUP: enable_pin_setup <=
					(enable_pin_setup & ~pmbus_cmd_pkg::PIN_WMASK) | (b_data & pmbus_cmd_pkg::PIN_WMASK);
				pmbus_cmd_pkg::CMD_LOCK: write_lock <= b_data & pmbus_cmd_pkg::LOCK_WMASK;
				default: ;
			endcase
		end
	end

	// ***************************
	// converter enable and margin
	// ***************************
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			O_OUTPUT_ON <= 1'b0;
			O_MARGIN    <= 2'h0;
		end else begin
			O_MARGIN <= run_margin_control[pmbus_cmd_pkg::MARGIN_LSB +: 2];
			O_OUTPUT_ON <= !enable_pin_setup[pmbus_cmd_pkg::PIN_USE_BIT] ||
				((!enable_pin_setup[pmbus_cmd_pkg::PIN_CMD_BIT] ||
				run_margin_control[pmbus_cmd_pkg::RUN_ON_BIT]) &&
				(!enable_pin_setup[pmbus_cmd_pkg::PIN_PIN_BIT] ||
				(pin_s == enable_pin_setup[pmbus_cmd_pkg::PIN_POL_BIT])));
		end
	end

	// ***************************
	// fault flags and alert
	// ***************************
	always_comb begin
		next_cml = comm_fault_flags;
		if (commit && b_cmd == pmbus_cmd_pkg::CMD_CLEAR)
			next_cml = 8'h00;
		next_cml[pmbus_cmd_pkg::CML_CMD_BIT] = next_cml[pmbus_cmd_pkg::CML_CMD_BIT] | rd_err |
			(wr_done & (~known | ~permitted));
		next_cml[pmbus_cmd_pkg::CML_DATA_BIT] = next_cml[pmbus_cmd_pkg::CML_DATA_BIT] |
			(wr_done & known & permitted & ((~len_ok & ~pec_bad) | data_bad));
		next_cml[pmbus_cmd_pkg::CML_PEC_BIT] = next_cml[pmbus_cmd_pkg::CML_PEC_BIT] |
			(wr_done & known & pec_bad);
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			comm_fault_flags <= 8'h00;
			O_FAULT_FLAGS    <= 8'h00;
			O_ALERT_OE       <= 1'b0;
			O_ALERT_OUT      <= 1'b0;
			// open drain: only the enable moves, the driven value stays low
			O_SDA_OUT        <= 1'b0;
		end else begin
			comm_fault_flags <= next_cml;
			// a new fault in the clearing cycle survives the clear
			O_FAULT_FLAGS <= ((commit && b_cmd == pmbus_cmd_pkg::CMD_CLEAR) ? 8'h00 :
				O_FAULT_FLAGS) | I_FAULT_SET;
			O_ALERT_OE <= (|O_FAULT_FLAGS) | (|comm_fault_flags);
		end
	end

	// ***************************
	// non-volatile store requests
	// ***************************
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			O_NVM_STORE_ALL <= 1'b0;
			O_NVM_STORE_ONE <= 1'b0;
			O_NVM_CODE      <= 8'h00;
			O_NVM_DATA      <= 8'h00;
			O_NVM_BUSY      <= 1'b0;
			wait_cnt        <= '0;
		end else begin
			O_NVM_STORE_ALL <= commit && b_cmd == pmbus_cmd_pkg::CMD_STORE_ALL;
			O_NVM_STORE_ONE <= commit && b_cmd == pmbus_cmd_pkg::CMD_STORE_ONE;
			if (commit && b_cmd == pmbus_cmd_pkg::CMD_STORE_ONE) begin
				O_NVM_CODE <= b_data;
				O_NVM_DATA <= reg_value(b_data);
			end
			if (commit && b_cmd == pmbus_cmd_pkg::CMD_STORE_ALL) begin
				wait_cnt   <= pmbus_cmd_pkg::WAIT_W'(NVM_WAIT_CYCLES);
				O_NVM_BUSY <= 1'b1;
			end else if (wait_cnt != '0) begin
				wait_cnt   <= wait_cnt - 1'b1;
				O_NVM_BUSY <= wait_cnt != pmbus_cmd_pkg::WAIT_W'(1);
			end
		end
	end

endmodule

// >>> dv/pmbus_command_handler_props.sv
`timescale 1ns/1ps
module pmbus_command_handler_props #(
	parameter int NVM_WAIT_CYCLES = 20
) (
	input wire logic       I_CLK,
	input wire logic       I_RESET_N,
	input wire logic [7:0] I_FAULT_SET,
	input wire logic       O_SDA_OUT,
	input wire logic       O_ALERT_OUT,
	input wire logic       O_ALERT_OE,
	input wire logic [7:0] O_FAULT_FLAGS,
	input wire logic       O_NVM_STORE_ALL,
	input wire logic       O_NVM_STORE_ONE,
	input wire logic [7:0] O_NVM_CODE,
	input wire logic [7:0] O_NVM_DATA,
	input wire logic       O_NVM_BUSY
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RESET_N);
	int busy_cnt;
	// counts busy cycles of the current save
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N || !O_NVM_BUSY)
			busy_cnt <= 0;
		else
			busy_cnt <= busy_cnt + 1;
	end
	AST_BUSY_START: assert property (O_NVM_STORE_ALL |-> $rose(O_NVM_BUSY))
		else $error("busy did not start with the save-all pulse");
	AST_BUSY_LEN: assert property ($fell(O_NVM_BUSY) |-> busy_cnt == NVM_WAIT_CYCLES)
		else $error("save-all busy time wrong");
	AST_ALL_PULSE: assert property (O_NVM_STORE_ALL |=> !O_NVM_STORE_ALL)
		else $error("save-all pulse too long");
	AST_ONE_PULSE: assert property (O_NVM_STORE_ONE |=> !O_NVM_STORE_ONE && $stable(O_NVM_CODE)
		&& $stable(O_NVM_DATA)) else $error("single save pulse or code not held");
	AST_FAULT_LATCH: assert property (|I_FAULT_SET |=>
		(O_FAULT_FLAGS & $past(I_FAULT_SET)) == $past(I_FAULT_SET)) else $error("fault not latched");
	AST_FAULT_SOURCE: assert property ((O_FAULT_FLAGS & ~$past(O_FAULT_FLAGS)
		& ~$past(I_FAULT_SET)) == 8'h00) else $error("flag set without a fault");
	AST_CLEAR_ALL: assert property (($past(O_FAULT_FLAGS) & ~O_FAULT_FLAGS) != 8'h00
		|-> (O_FAULT_FLAGS & ~$past(I_FAULT_SET)) == 8'h00) else $error("partial clear");
	AST_ALERT_ON: assert property (|O_FAULT_FLAGS |=> O_ALERT_OE)
		else $error("alert not raised for a flag");
	AST_ALERT_OFF: assert property ($fell(O_ALERT_OE) |-> $past(O_FAULT_FLAGS) == 8'h00)
		else $error("alert released with flags set");
	AST_OPEN_DRAIN: assert property (!O_SDA_OUT && !O_ALERT_OUT)
		else $error("open drain pin driven high");
	cover property (O_NVM_STORE_ALL);
	cover property (O_NVM_STORE_ONE);
	cover property ($fell(O_ALERT_OE));
endmodule
bind pmbus_command_handler pmbus_command_handler_props #(.NVM_WAIT_CYCLES(NVM_WAIT_CYCLES)) u_props (
	.I_CLK, .I_RESET_N, .I_FAULT_SET, .O_SDA_OUT, .O_ALERT_OUT, .O_ALERT_OE, .O_FAULT_FLAGS,
	.O_NVM_STORE_ALL, .O_NVM_STORE_ONE, .O_NVM_CODE, .O_NVM_DATA, .O_NVM_BUSY);

// >>> dv/pmbus_command_handler_tb.sv
`timescale 1ns/1ps
module pmbus_command_handler_tb;
	localparam int NVM_WAIT = 20;
	logic       clk = 1'b0, rst_n = 1'b0, pin = 1'b1, got_v = 1'b0;
	logic [7:0] fset = 8'h00, r, rd, got, flags, nv_code, nv_data;
	logic [7:0] shd [3], exp_q [$];
	logic [7:0] lk [4] = '{8'h20, 8'h40, 8'h40, 8'h80};
	logic [7:0] tg [4] = '{8'h02, 8'h02, 8'h01, 8'h01};
	logic       ok [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	logic       scl, sda, sda_oe, alert, on, st_all, st_one, busy;
	logic [1:0] margin;
	int         num_errors = 0, checks_done = 0, busy_n = 0, all_n = 0, one_n = 0, cyc = 0;
	always #4 clk = !clk;
	pmbus_command_handler #(.NVM_WAIT_CYCLES(NVM_WAIT)) u_dut (.I_CLK(clk), .I_RESET_N(rst_n),
		.I_SCL(scl), .I_SDA(sda), .O_SDA_OUT(), .O_SDA_OE(sda_oe), .O_ALERT_OUT(),
		.O_ALERT_OE(alert), .I_ENABLE_PIN(pin), .I_FAULT_SET(fset), .O_OUTPUT_ON(on),
		.O_MARGIN(margin), .O_FAULT_FLAGS(flags), .O_NVM_STORE_ALL(st_all),
		.O_NVM_STORE_ONE(st_one), .O_NVM_CODE(nv_code), .O_NVM_DATA(nv_data), .O_NVM_BUSY(busy));
	pmbus_host_model u_host (.i_clk(clk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
	task automatic finish_test();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ***************************
	// result watcher
	// ***************************
	always @(posedge clk) begin
		cyc++;
		busy_n += int'(busy === 1'b1);
		all_n += int'(st_all === 1'b1);
		one_n += int'(st_one === 1'b1);
		if (got_v) begin
			checks_done++;
			if (got !== exp_q[0]) begin
				num_errors++;
				$display("[FAIL] %0t expected %h got %h", $time, exp_q[0], got);
			end
			void'(exp_q.pop_front());
		end
		if (cyc == 80000) begin
			num_errors++;
			finish_test();
		end
	end
	task automatic chk(input logic [7:0] e, input logic [7:0] a);
		exp_q.push_back(e);
		got <= a;
		got_v <= 1'b1;
		@(posedge clk);
		got_v <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdchk(input logic [7:0] c, input logic [7:0] e);
		u_host.read(c, rd);
		chk(e, rd);
	endtask
	task automatic clear();
		u_host.write(8'h03, 8'h00, 1, 2'h0);
	endtask
	// ***************************
	// main sequence
	// ***************************
	initial begin
		r = 8'($urandom(32'h13a030e5));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		shd = '{8'h00, 8'h16, 8'h00};
		chk(8'h01, {7'h00, on});
		rdchk(8'h01, 8'h00);
		rdchk(8'h02, 8'h16);
		rdchk(8'h10, 8'h00);
		rdchk(8'h7e, 8'h00);
		pin <= 1'b0;
		u_host.write(8'h02, 8'h1a, 2, 2'h1);
		u_host.write(8'h01, 8'h80, 2, 2'h0);
		chk(8'h01, {7'h00, on});
		u_host.write(8'h02, 8'h1e, 2, 2'h0);
		chk(8'h00, {7'h00, on});
		pin <= 1'b1;
		repeat (6) @(posedge clk);
		chk(8'h01, {7'h00, on});
		// active-low pin polarity, then enable pin ignored
		u_host.write(8'h02, 8'h1c, 2, 2'h0);
		chk(8'h00, {7'h00, on});
		pin <= 1'b0;
		repeat (6) @(posedge clk);
		chk(8'h01, {7'h00, on});
		u_host.write(8'h02, 8'h0e, 2, 2'h0);
		chk(8'h01, {7'h00, on});
		pin <= 1'b1;
		u_host.write(8'h02, 8'h1e, 2, 2'h0);
		shd[1] = 8'h1e;
		for (int i = 0; i < 4; i++) begin
			r = (8'($urandom) & 8'h8c) | 8'(i << 4);
			u_host.write(8'h01, r, 2, 2'h0);
			chk({6'h00, r[5:4]}, {6'h00, margin});
			rdchk(8'h01, r);
		end
		shd[0] = r;
		r = 8'($urandom) | 8'h01;
		fset <= r;
		@(posedge clk);
		fset <= 8'h00;
		repeat (2) @(posedge clk);
		chk(r, flags);
		chk(8'h01, {7'h00, alert});
		clear();
		chk(8'h00, flags);
		chk(8'h00, {7'h00, alert});
		// unknown code, short write, corrupted check byte
		for (int i = 0; i < 3; i++) begin
			u_host.write(i == 0 ? 8'h55 : 8'h01, 8'h00, i == 1 ? 1 : 2, i == 2 ? 2'h3 : 2'h0);
			rdchk(8'h7e, 8'h80 >> i);
			clear();
		end
		rdchk(8'h01, shd[0]);
		for (int i = 0; i < 4; i++) begin
			u_host.write(8'h10, lk[i], 2, 2'h0);
			rdchk(8'h10, lk[i]);
			r = tg[i] == 8'h02 ? (8'($urandom) & 8'h04) | 8'h1a : 8'($urandom) & 8'hbc;
			u_host.write(tg[i], r, 2, 2'h0);
			if (ok[i]) shd[tg[i] - 8'h01] = r;
			rdchk(tg[i], shd[tg[i] - 8'h01]);
			rdchk(8'h7e, ok[i] ? 8'h00 : 8'h80);
			u_host.write(8'h10, 8'h00, 2, 2'h0);
			clear();
		end
		u_host.write(8'h10, 8'h60, 2, 2'h0);
		rdchk(8'h10, 8'h00);
		rdchk(8'h7e, 8'h40);
		clear();
		// page write is taken, unknown read returns idle and flags
		u_host.write(8'h00, r, 2, 2'h0);
		rdchk(8'h7e, 8'h00);
		rdchk(8'h55, 8'hff);
		rdchk(8'h7e, 8'h80);
		clear();
		// single save of an unreadable code is refused without a pulse
		u_host.write(8'h13, 8'h55, 2, 2'h0);
		rdchk(8'h7e, 8'h40);
		clear();
		u_host.write(8'h13, 8'h02, 2, 2'h0);
		chk(8'h01, 8'(one_n));
		chk(8'h02, nv_code);
		chk(shd[1], nv_data);
		u_host.write(8'h11, 8'h00, 1, 2'h0);
		// host keeps quiet until the save is done
		for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge clk);
		chk(8'h01, 8'(all_n));
		chk(8'(NVM_WAIT), 8'(busy_n));
		rdchk(8'h02, shd[1]);
		finish_test();
	end
endmodule

// >>> dv/pmbus_host_model.sv
`timescale 1ns/1ps
module pmbus_host_model #(
	parameter logic [6:0] ADDR = 7'h40
) (
	// clock
	input  wire logic i_clk,
	// bus
	input  wire logic i_sda_oe,
	output logic      o_scl,
	output logic      o_sda
);
	logic       pull = 1'b0;
	logic [7:0] crc;
	// open drain: either party pulls the line low
	assign o_sda = !(pull || i_sda_oe);
	initial o_scl = 1'b1;
	task automatic hold();
		repeat (8) @(posedge i_clk);
	endtask
	task automatic crc_add(input logic [7:0] b);
		crc = crc ^ b;
		repeat (8) crc = crc[7] ? {crc[6:0], 1'b0} ^ 8'h07 : {crc[6:0], 1'b0};
	endtask
	task automatic clk_bit(input logic b, output logic r);
		pull <= !b;
		hold();
		o_scl <= 1'b1;
		hold();
		r = o_sda;
		o_scl <= 1'b0;
		hold();
	endtask
	task automatic put(input logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) clk_bit(b[i], r);
		clk_bit(1'b1, r);
		crc_add(b);
	endtask
	task automatic start();
		pull <= 1'b0;
		hold();
		o_scl <= 1'b1;
		hold();
		pull <= 1'b1;
		hold();
		o_scl <= 1'b0;
		hold();
		crc = 8'h00;
	endtask
	task automatic stop();
		pull <= 1'b1;
		hold();
		o_scl <= 1'b1;
		hold();
		pull <= 1'b0;
		hold();
	endtask
	// n bytes counting the code; p 1 adds a good check byte, 3 a corrupted one
	task automatic write(input logic [7:0] c, input logic [7:0] d, input int n,
		input logic [1:0] p);
		start();
		put({ADDR, 1'b0});
		put(c);
		if (n > 1) put(d);
		if (p != 2'h0) put(crc ^ {7'h00, p[1]});
		stop();
	endtask
	task automatic read(input logic [7:0] c, output logic [7:0] d);
		logic r;
		start();
		put({ADDR, 1'b0});
		put(c);
		start();
		put({ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, r);
			d[i] = r;
		end
		clk_bit(1'b1, r);
		stop();
	endtask
endmodule
